// ==== inc/lnb_ctrl_map.vh ====
/*
 Constants of the two-wire control/status port: chip address, register
 indices, bit positions, timing counts and the APB register map.
 Assumes a 20 MHz system clock and a 32-bit APB master.
*/
`ifndef LNB_CTRL_MAP_VH
`define LNB_CTRL_MAP_VH

`define CHIP_ADDR_HI     5'h02
`define CTRL_INDEX       8'h00
`define STAT_INDEX       8'h00
`define CTRL_RESET       8'h00

`define OUTPUT_ON_BIT    4
`define LIMIT_BOOST_BIT  6

`define ST_DISABLED      0
`define ST_OVERCURRENT   2
`define ST_CABLE_OPEN    3
`define ST_OUTPUT_LOW    4
`define ST_THERMAL       6
`define ST_UNDERVOLTAGE  7

`define CLK_MHZ          20
`define SHORT_TIME_US    45000
// SHORT_TIME_US times CLK_MHZ, sized for the 20-bit short counter
`define SHORT_CYC        20'd900000

`define APB_CTRL_OFS     8'h00
`define APB_STAT_OFS     8'h04
`define APB_LIVE_OFS     8'h08

`endif

// ==== design/lnb_ctrl_port.v ====
/*
 Two-wire target port with control byte, latched and live fault status and an
 open-drain interrupt; control and status are mirrored onto APB.
 Assumes the bus lines and fault indications are asynchronous inputs and
 that the APB master holds each request until PREADY.
*/
`timescale 1ns/1ns
`include "lnb_ctrl_map.vh"

module lnb_ctrl_port #(
    parameter [19:0] SHORT_LIMIT = `SHORT_CYC
)(
    input  wire        CLK,
    input  wire        RST_B,
    input  wire        CE,
    input  wire        SCL_IN,
    input  wire        SDA_IN,
    output reg         SDA_OUT,
    output reg         SDA_OE,
    output reg         IRQ_OUT,
    output reg         IRQ_OE,
    input  wire [1:0]  ADDR_SEL,
    input  wire        UNDERVOLT_IN,
    input  wire        SHORT_IN,
    input  wire        OVERTEMP_IN,
    input  wire        CABLE_OPEN_IN,
    input  wire        OUTPUT_LOW_IN,
    output reg         OUTPUT_ON,
    output reg  [7:0]  CTRL_BYTE,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR
);

    // ==========================================================
    // states
    // ==========================================================
    localparam [5:0] S_IDLE   = 6'h01;
    localparam [5:0] S_CHIP   = 6'h02;
    localparam [5:0] S_INDEX  = 6'h04;
    localparam [5:0] S_DATA   = 6'h08;
    localparam [5:0] S_SEND   = 6'h10;
    localparam [5:0] S_IGNORE = 6'h20;
    localparam       NSYNC    = 9;
    // bus lines idle high, address and fault inputs idle low;
    // a fault input seen high after reset would latch a false fault
    localparam [NSYNC-1:0] SYNC_INIT = 9'h003;

    // ==========================================================
    // input synchronisers
    // ==========================================================
    wire [NSYNC-1:0] raw_in;
    reg  [NSYNC-1:0] sync1_reg;
    reg  [NSYNC-1:0] sync2_reg;
    reg  [NSYNC-1:0] sync3_reg;
    reg  [NSYNC-1:0] filt_reg;
    reg              scl_prev_reg;
    reg              sda_prev_reg;

    assign raw_in = {OUTPUT_LOW_IN, CABLE_OPEN_IN, OVERTEMP_IN, SHORT_IN,
                     UNDERVOLT_IN, ADDR_SEL, SDA_IN, SCL_IN};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1)
        begin : g_sync
            always @(posedge CLK)
            begin
                if (!RST_B)
                begin
                    sync1_reg[gi] <= SYNC_INIT[gi];
                    sync2_reg[gi] <= SYNC_INIT[gi];
                    sync3_reg[gi] <= SYNC_INIT[gi];
                    filt_reg[gi]  <= SYNC_INIT[gi];
                end
                else if (CE)
                begin
                    sync1_reg[gi] <= raw_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    if (sync2_reg[gi] == sync3_reg[gi])
                        filt_reg[gi] <= sync3_reg[gi];
                end
            end
        end
    endgenerate

    wire       scl        = filt_reg[0];
    wire       sda        = filt_reg[1];
    wire [1:0] addr_low   = filt_reg[3:2];
    wire       uv_live    = filt_reg[4];
    wire       short_live = filt_reg[5];
    wire       hot_live   = filt_reg[6];
    wire       cable_live = filt_reg[7];
    wire       low_live   = filt_reg[8];

    // edge detection
    // only filtered levels reach the sequencer; raw pins never do
    wire scl_rise = scl & ~scl_prev_reg;
    wire scl_fall = ~scl & scl_prev_reg;
    wire start_ev = scl & scl_prev_reg & ~sda & sda_prev_reg;
    wire stop_ev  = scl & scl_prev_reg & sda & ~sda_prev_reg;

    // ==========================================================
    // protocol state
    // ==========================================================
    reg [5:0]  state_reg;
    reg [5:0]  after_reg;
    reg [3:0]  bit_cnt_reg;
    reg        ack_phase_reg;
    reg [7:0]  shift_reg;
    reg [7:0]  tx_reg;
    reg        status_ack_reg;
    reg [7:0]  ctrl_reg;
    reg        i2c_wr_reg;

    // fault state
    reg        uv_lat_reg;
    reg        oc_lat_reg;
    reg        hot_lat_reg;
    reg        irq_pend_reg;
    reg        dis_reg;
    reg        uv_prev_reg;
    reg        hot_prev_reg;
    reg [19:0] short_cnt_reg;

    wire oc_event = short_live && (short_cnt_reg == SHORT_LIMIT - 20'h00001);
    wire [7:0] status_byte;

    assign status_byte[`ST_DISABLED]     = dis_reg;
    assign status_byte[1]                = 1'b0;
    assign status_byte[`ST_OVERCURRENT]  = oc_lat_reg;
    assign status_byte[`ST_CABLE_OPEN]   = cable_live;
    assign status_byte[`ST_OUTPUT_LOW]   = low_live;
    assign status_byte[5]                = 1'b0;
    assign status_byte[`ST_THERMAL]      = hot_lat_reg;
    assign status_byte[`ST_UNDERVOLTAGE] = uv_lat_reg;

    // bit counter stops at eight; the ninth clock is the ack phase
    // upper five address bits fixed, lower two from the select pins
    wire addr_match = (shift_reg[7:3] == `CHIP_ADDR_HI) &&
                      (shift_reg[2:1] == addr_low);

    always @(posedge CLK)
    begin
        if (!RST_B)
        begin
            scl_prev_reg   <= 1'b1;
            sda_prev_reg   <= 1'b1;
            state_reg      <= S_IDLE;
            after_reg      <= S_IDLE;
            bit_cnt_reg    <= 4'h0;
            ack_phase_reg  <= 1'b0;
            shift_reg      <= 8'h00;
            tx_reg         <= 8'h00;
            status_ack_reg <= 1'b0;
            i2c_wr_reg     <= 1'b0;
            SDA_OE         <= 1'b0;
            SDA_OUT        <= 1'b0;
        end
        else if (CE)
        begin
            scl_prev_reg   <= scl;
            sda_prev_reg   <= sda;
            status_ack_reg <= 1'b0;
            i2c_wr_reg     <= 1'b0;
            // restart on start, abandon on stop
            if (start_ev || stop_ev)
            begin
                state_reg     <= start_ev ? S_CHIP : S_IDLE;
                bit_cnt_reg   <= 4'h0;
                ack_phase_reg <= 1'b0;
                SDA_OE        <= 1'b0;
            end
            else if (scl_rise)
            begin
                if (!ack_phase_reg && bit_cnt_reg != 4'h8)
                begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    shift_reg   <= {shift_reg[6:0], sda};
                end
                // host acknowledge sampled on ninth clock
                else if (ack_phase_reg && state_reg == S_SEND && !sda)
                    status_ack_reg <= 1'b1;
            end
            else if (scl_fall)
            begin
                if (ack_phase_reg)
                begin
                    ack_phase_reg <= 1'b0;
                    bit_cnt_reg   <= 4'h0;
                    state_reg     <= after_reg;
                    tx_reg        <= status_byte;
                    SDA_OE        <= (after_reg == S_SEND) & ~status_byte[7];
                end
                else if (bit_cnt_reg == 4'h8)
                begin
                    case (state_reg)
                        S_CHIP:
                        begin
                            if (addr_match)
                            begin
                                SDA_OE        <= 1'b1;
                                ack_phase_reg <= 1'b1;
                                after_reg     <= shift_reg[0] ? S_SEND
                                                              : S_INDEX;
                            end
                            else
                                state_reg <= S_IGNORE;
                        end
                        S_INDEX:
                        begin
                            if (shift_reg == `CTRL_INDEX ||
                                shift_reg == `STAT_INDEX)
                            begin
                                SDA_OE        <= 1'b1;
                                ack_phase_reg <= 1'b1;
                                after_reg     <= S_DATA;
                            end
                            else
                                state_reg <= S_IGNORE;
                        end
                        S_DATA:
                        begin
                            SDA_OE        <= 1'b1;
                            ack_phase_reg <= 1'b1;
                            i2c_wr_reg    <= 1'b1;
                            after_reg     <= S_IGNORE;
                        end
                        S_SEND:
                        begin
                            SDA_OE        <= 1'b0;
                            ack_phase_reg <= 1'b1;
                            after_reg     <= S_IGNORE;
                        end
                        default:
                            state_reg <= state_reg;
                    endcase
                end
                else if (state_reg == S_SEND)
                begin
                    tx_reg <= {tx_reg[6:0], 1'b0};
                    SDA_OE <= ~tx_reg[6];
                end
            end
        end
    end

    // ==========================================================
    // control register and APB slave
    // ==========================================================
    // one wait state: ready follows the first access-phase edge
    // unmapped offsets answer with an error and read as zero
    wire apb_access = PSEL & PENABLE & ~PREADY;
    wire apb_map    = (PADDR == `APB_CTRL_OFS) || (PADDR == `APB_STAT_OFS) ||
                      (PADDR == `APB_LIVE_OFS);

    always @(posedge CLK)
    begin
        if (!RST_B)
        begin
            ctrl_reg <= `CTRL_RESET;
            PREADY   <= 1'b0;
            PSLVERR  <= 1'b0;
            PRDATA   <= 32'h00000000;
        end
        else if (CE)
        begin
            if (i2c_wr_reg)
                ctrl_reg <= shift_reg;
            else if (apb_access && PWRITE && PADDR == `APB_CTRL_OFS)
                ctrl_reg <= PWDATA[7:0];
            PREADY  <= apb_access;
            PSLVERR <= apb_access & ~apb_map;
            if (apb_access && !PWRITE)
            begin
                case (PADDR)
                    `APB_CTRL_OFS: PRDATA <= {24'h000000, ctrl_reg};
                    `APB_STAT_OFS: PRDATA <= {24'h000000, status_byte};
                    `APB_LIVE_OFS: PRDATA <= {21'h000000, state_reg,
                                              irq_pend_reg, OUTPUT_ON,
                                              uv_live, short_live,
                                              hot_live};
                    default:       PRDATA <= 32'h00000000;
                endcase
            end
            else
                PRDATA <= 32'h00000000;
        end
    end

    // ==========================================================
    // fault latches, interrupt, output enable
    // ==========================================================
    always @(posedge CLK)
    begin
        if (!RST_B)
        begin
            uv_lat_reg    <= 1'b1;
            oc_lat_reg    <= 1'b0;
            hot_lat_reg   <= 1'b0;
            irq_pend_reg  <= 1'b1;
            uv_prev_reg   <= 1'b0;
            hot_prev_reg  <= 1'b0;
            short_cnt_reg <= 20'h00000;
            dis_reg       <= 1'b1;
            IRQ_OE        <= 1'b1;
            IRQ_OUT       <= 1'b0;
            OUTPUT_ON     <= 1'b0;
            CTRL_BYTE     <= `CTRL_RESET;
        end
        else if (CE)
        begin
            uv_prev_reg  <= uv_live;
            hot_prev_reg <= hot_live;
            if (!short_live || !OUTPUT_ON)
                short_cnt_reg <= 20'h00000;
            else if (!oc_event)
                short_cnt_reg <= short_cnt_reg + 20'h00001;
            // latch, cleared by host ack when cause gone
            // a live undervoltage or thermal cause keeps its latch set through any ack
            uv_lat_reg  <= uv_live | (uv_lat_reg & ~status_ack_reg);
            oc_lat_reg  <= (oc_event & OUTPUT_ON) |
                           (oc_lat_reg & ~status_ack_reg);
            hot_lat_reg <= hot_live | (hot_lat_reg & ~status_ack_reg);
            // new undervoltage, thermal or overcurrent fault raises interrupt, set beats clear
            if ((uv_live & ~uv_prev_reg) | (hot_live & ~hot_prev_reg) |
                (oc_event & OUTPUT_ON))
                irq_pend_reg <= 1'b1;
            else if (status_ack_reg)
                irq_pend_reg <= 1'b0;
            IRQ_OE    <= irq_pend_reg;
            IRQ_OUT   <= 1'b0;
            // enable gated by latched faults
            // enable bit is ignored until a read clears the latches
            OUTPUT_ON <= ctrl_reg[`OUTPUT_ON_BIT] & ~uv_lat_reg &
                         ~oc_lat_reg & ~hot_lat_reg & ~uv_live & ~hot_live;
            dis_reg   <= ~(ctrl_reg[`OUTPUT_ON_BIT] & ~uv_lat_reg &
                           ~oc_lat_reg & ~hot_lat_reg & ~uv_live &
                           ~hot_live);
            CTRL_BYTE <= ctrl_reg;
        end
    end

endmodule // lnb_ctrl_port

// ==== verification/lnb_ctrl_port_properties.sv ====
/*
 Checker of the two-wire port pins of lnb_ctrl_port.
 Assumes binding onto the design top and one clock domain.
*/
`timescale 1ns/1ns
`include "lnb_ctrl_map.vh"
module lnb_ctrl_port_chk #(
    parameter [19:0] SHORT_LIMIT = 20'd50
)(
    input logic        CLK,
    input logic        RST_B,
    input logic        SCL_IN,
    input logic        SDA_OUT,
    input logic        SDA_OE,
    input logic        IRQ_OUT,
    input logic        IRQ_OE,
    input logic        UNDERVOLT_IN,
    input logic        SHORT_IN,
    input logic        OVERTEMP_IN,
    input logic        OUTPUT_ON,
    input logic [7:0]  CTRL_BYTE
);
// ========================
// helper counters
logic [3:0]  fault_age;
logic [3:0]  scl_age;
logic        scl_q;
logic [20:0] short_cnt;
always @(posedge CLK)
begin
    scl_q <= SCL_IN;
    if (!RST_B || UNDERVOLT_IN || SHORT_IN || OVERTEMP_IN)
        fault_age <= 4'h0;
    else if (fault_age != 4'hF)
        fault_age <= fault_age + 4'h1;
    if (!RST_B || (SCL_IN && !scl_q))
        scl_age <= 4'h0;
    else if (scl_age != 4'hF)
        scl_age <= scl_age + 4'h1;
    if (RST_B && SHORT_IN && OUTPUT_ON)
        short_cnt <= short_cnt + 21'h1;
    else
        short_cnt <= 21'h0;
end
// ========================
// properties
default clocking @(posedge CLK); endclocking
default disable iff (!RST_B);
sequence s_hot;
    $rose(OVERTEMP_IN) ##1 OVERTEMP_IN [*7];
endsequence
property p_irq_od;
    IRQ_OUT == 1'h0 && SDA_OUT == 1'h0;
endproperty
property p_reset_vals;
    $rose(RST_B) |-> CTRL_BYTE == `CTRL_RESET && !OUTPUT_ON && IRQ_OE;
endproperty
property p_hot;
    s_hot |-> IRQ_OE && !OUTPUT_ON;
endproperty
property p_uv_off;
    UNDERVOLT_IN [*8] |-> !OUTPUT_ON;
endproperty
property p_on_bit;
    (!CTRL_BYTE[`OUTPUT_ON_BIT]) [*3] |-> !OUTPUT_ON;
endproperty
property p_irq_cause;
    $rose(IRQ_OE) |-> fault_age < 4'hC;
endproperty
property p_short_off;
    short_cnt <= SHORT_LIMIT + 8;
endproperty
property p_irq_clear;
    $fell(IRQ_OE) |-> scl_age < 4'hE;
endproperty
property p_ack_hold;
    $rose(SDA_OE) |-> SDA_OE [*6];
endproperty
a_irq_od: assert property (p_irq_od) else $error("pin driven high");
a_reset_vals: assert property (p_reset_vals) else $error("reset");
a_hot: assert property (p_hot) else $error("thermal");
a_uv_off: assert property (p_uv_off) else $error("uv output");
a_on_bit: assert property (p_on_bit) else $error("enable bit");
a_irq_cause: assert property (p_irq_cause) else $error("irq cause");
a_short_off: assert property (p_short_off) else $error("short");
a_irq_clear: assert property (p_irq_clear) else $error("irq clr");
a_ack_hold: assert property (p_ack_hold) else $error("ack len");
endmodule // lnb_ctrl_port_chk

bind lnb_ctrl_port lnb_ctrl_port_chk #(.SHORT_LIMIT(SHORT_LIMIT)) chk_u (
    .CLK(CLK), .RST_B(RST_B), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .IRQ_OUT(IRQ_OUT), .IRQ_OE(IRQ_OE),
    .UNDERVOLT_IN(UNDERVOLT_IN), .SHORT_IN(SHORT_IN),
    .OVERTEMP_IN(OVERTEMP_IN), .OUTPUT_ON(OUTPUT_ON),
    .CTRL_BYTE(CTRL_BYTE));

// ==== verification/lnb_host_model.sv ====
/*
 Two-wire host model: makes the bus clock, pulls data low or releases it.
 Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ns
module lnb_host_model (
    output logic scl,
    output logic sda_low,
    input  logic sda
);
initial
begin
    scl = 1'h1;
    sda_low = 1'h0;
end
task start_c;
    // extra 10 ns keeps pin changes off the clock edges
    #110 sda_low = 1'h0;
    #100 scl = 1'h1;
    #100 sda_low = 1'h1;
    #100 scl = 1'h0;
endtask
task stop_c;
    #100 sda_low = 1'h1;
    #100 scl = 1'h1;
    #100 sda_low = 1'h0;
    #100;
endtask
task xbit(input logic b, output logic r);
    // long low phase: the device releases data about 250 ns after a fall
    #150 sda_low = !b;
    #100 scl = 1'h1;
    #140 r = sda;
    #10 scl = 1'h0;
endtask
task xbyte(input logic [7:0] d, input logic ak, output logic [7:0] q,
           output logic a);
    for (int i = 7; i >= 0; i--)
        xbit(d[i], q[i]);
    xbit(ak, a);
endtask
endmodule // lnb_host_model

// ==== verification/two_wire_control_status_irq_tb_top.sv ====
/*
 Self-checking bench of lnb_ctrl_port with a two-wire host model.
 Assumes the checker is bound and the map header is on the include path.
*/
`timescale 1ns/1ns
`include "lnb_ctrl_map.vh"
module two_wire_control_status_irq_tb_top;
localparam [19:0] SHORT_LIM = 20'd50;
localparam [6:0]  CHIP = {`CHIP_ADDR_HI, 2'h2};
logic        clk, rst_b, uv, short_in, hot, cable, low_out;
logic        psel, penable, pwrite;
logic [7:0]  paddr;
logic [1:0]  addr_sel;
logic [31:0] pwdata;
wire  [31:0] prdata;
wire  [7:0]  ctrl_byte;
wire         pready, pslverr, sda_oe, irq_oe, output_on, scl, sda_low;
wire         sda = !(sda_low | sda_oe);
int          n_errors, n_tests;
lnb_ctrl_port #(.SHORT_LIMIT(SHORT_LIM)) dut_u (
    .CLK(clk), .RST_B(rst_b), .CE(1'h1), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(), .SDA_OE(sda_oe), .IRQ_OUT(), .IRQ_OE(irq_oe),
    .ADDR_SEL(addr_sel), .UNDERVOLT_IN(uv), .SHORT_IN(short_in),
    .OVERTEMP_IN(hot), .CABLE_OPEN_IN(cable), .OUTPUT_LOW_IN(low_out),
    .OUTPUT_ON(output_on), .CTRL_BYTE(ctrl_byte), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
lnb_host_model host_u (.scl(scl), .sda_low(sda_low), .sda(sda));
initial
begin
    clk = 1'h0;
    forever #25 clk = ~clk;
end
// ========================
// shared tasks
task chk(input logic [32:0] s, input logic [32:0] e);
    n_tests++;
    if (s !== e)
        begin
        n_errors++;
        $display("Error t=%0t seen=%h exp=%h", $time, s, e);
        end
endtask
task wait_c(input int n);
    repeat (n) @(posedge clk);
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
endtask
task wr(input logic [6:0] ad, input logic [7:0] d, input logic [2:0] ex);
    logic [7:0] q;
    logic [2:0] a;
    host_u.start_c();
    host_u.xbyte({ad, 1'h0}, 1'h1, q, a[2]);
    host_u.xbyte(`CTRL_INDEX, 1'h1, q, a[1]);
    host_u.xbyte(d, 1'h1, q, a[0]);
    host_u.stop_c();
    chk(a, ex);
    wait_c(4);
endtask
// address, index, stop, start, read address
task rd(output logic [7:0] s);
    logic [7:0] q;
    logic [3:0] a;
    host_u.start_c();
    host_u.xbyte({CHIP, 1'h0}, 1'h1, q, a[3]);
    host_u.xbyte(`STAT_INDEX, 1'h1, q, a[2]);
    host_u.stop_c();
    host_u.start_c();
    host_u.xbyte({CHIP, 1'h1}, 1'h1, q, a[1]);
    host_u.xbyte(8'hFF, 1'h0, s, a[0]);
    host_u.stop_c();
    chk(a, 4'h0);
    wait_c(8);
endtask
// ========================
// scenarios
task t_reset;
    logic [31:0] q;
    logic        e;
    logic [7:0]  s;
    apb(1'h0, `APB_CTRL_OFS, 32'h0, q, e);
    chk(q, 32'h0);
    chk(irq_oe, 1'h1);
    uv <= 1'h1;
    wait_c(12);
    uv <= 1'h0;
    wait_c(10);
    rd(s);
    chk(s & 8'h81, 8'h81);
    chk(irq_oe, 1'h0);
    rd(s);
    chk(s, 8'h01);
    $display("t_reset done");
endtask
task t_write;
    logic [7:0] q;
    logic       a;
    wr(CHIP, 8'h10, 3'h0);
    chk(output_on, 1'h1);
    chk(ctrl_byte, 8'h10);
    wr({`CHIP_ADDR_HI, 2'h1}, 8'h00, 3'h7);
    wr({5'h03, 2'h2}, 8'h00, 3'h7);
    addr_sel <= 2'h1;
    wait_c(8);
    wr({`CHIP_ADDR_HI, 2'h1}, 8'h10, 3'h0);
    addr_sel <= 2'h2;
    wait_c(8);
    host_u.start_c();
    host_u.xbyte({CHIP, 1'h0}, 1'h1, q, a);
    host_u.xbyte(`CTRL_INDEX, 1'h1, q, a);
    for (int i = 0; i < 4; i++)
        host_u.xbit(1'h0, a);
    host_u.start_c();
    host_u.stop_c();
    wait_c(4);
    chk(ctrl_byte, 8'h10);
    wr(CHIP, 8'h00, 3'h0);
    chk(output_on, 1'h0);
    $display("t_write done");
endtask
task t_live;
    logic [7:0] s;
    cable <= 1'h1;
    low_out <= 1'h1;
    wait_c(20);
    chk(irq_oe, 1'h0);
    rd(s);
    chk(s & 8'h18, 8'h18);
    cable <= 1'h0;
    low_out <= 1'h0;
    wait_c(10);
    rd(s);
    chk(s & 8'h18, 8'h00);
    $display("t_live done");
endtask
task t_hot;
    logic [7:0] s;
    wr(CHIP, 8'h10, 3'h0);
    hot <= 1'h1;
    wait_c(20);
    chk({irq_oe, output_on}, 2'h2);
    hot <= 1'h0;
    wait_c(20);
    chk(irq_oe, 1'h1);
    rd(s);
    chk(s, 8'h41);
    chk(irq_oe, 1'h0);
    rd(s);
    chk(s & 8'h40, 8'h00);
    $display("t_hot done");
endtask
task t_short;
    logic [7:0] s;
    wr(CHIP, 8'h10, 3'h0);
    chk(output_on, 1'h1);
    short_in <= 1'h1;
    wait_c(SHORT_LIM + 20);
    chk({irq_oe, output_on}, 2'h2);
    wr(CHIP, 8'h10, 3'h0);
    chk(output_on, 1'h0);
    short_in <= 1'h0;
    wait_c(10);
    rd(s);
    chk(s & 8'h04, 8'h04);
    wr(CHIP, 8'h10, 3'h0);
    chk(output_on, 1'h1);
    $display("t_short done");
endtask
task t_apb;
    logic [31:0] q;
    logic        e;
    apb(1'h1, `APB_CTRL_OFS, 32'h05, q, e);
    apb(1'h0, `APB_CTRL_OFS, 32'h0, q, e);
    chk({e, q}, 33'h05);
    chk(ctrl_byte, 8'h05);
    apb(1'h0, 8'h0C, 32'h0, q, e);
    chk({e, q}, 33'h100000000);
    $display("t_apb done");
endtask
task end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
initial
begin
    {rst_b, uv, short_in, hot, cable, low_out} = 6'h0;
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    addr_sel = 2'h2;
    wait_c(8);
    rst_b <= 1'h1;
    wait_c(4);
    t_reset;
    t_write;
    t_live;
    t_hot;
    t_short;
    t_apb;
    end_sim;
end
initial
begin
    #1000000;
    n_errors++;
    end_sim;
end
endmodule // two_wire_control_status_irq_tb_top
